// *** logic/psc_controller.sv ***
// Summary of operation
// - boot selects channel 1, its LED lit
// - channel changes only on button press
// - no data forwarded in failure state
// - switch clears stacks, drops keys 100 ms
// - keep four latest keys, wiped on switch
// - admit only HID class peripherals
// - reject re-enumeration as another class
// - merged stream only to selected channel
// - keyboard and mouse switch as pair
// - show lock key states on panel
// - tamper blows fuse, chase LEDs forever
// - failed battery at test acts as tamper
// - log tamper events with time stamp
// - remote tamper or battery kills remote
// - run self-test at every power-on
// - channel 1 held at boot forces failure
// - test buttons, tamper, firmware, isolation
// - test failure blinks LEDs, stops data
// - selected channel LED follows selection
//
// Local design decisions: the register addresses and the APB interface to the registers.
`include "psc_defines.svh"
`default_nettype none

module psc_controller #(
    parameter int unsigned N_CHAN       = 4,
    parameter int unsigned DISCARD_CYC  = `PSC_DISCARD_MS * (`PSC_CLK_HZ / 1000),
    parameter int unsigned DEBOUNCE_CYC = `PSC_DEBOUNCE_MS * (`PSC_CLK_HZ / 1000),
    parameter int unsigned BLINK_CYC    = `PSC_BLINK_MS * (`PSC_CLK_HZ / 1000)
) (
    input  wire logic              sys_clk_i,
    input  wire logic              nrst_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [11:0]       paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic [N_CHAN-1:0] btn_panel_i,
    input  wire logic [N_CHAN-1:0] btn_remote_i,
    input  wire logic              tamper_i,
    input  wire logic              batt_fail_i,
    input  wire logic              remote_tamper_i,
    input  wire logic              remote_batt_fail_i,
    input  wire logic              fuse_blown_i,
    input  wire logic              iso_echo_i,
    input  wire logic              fw_ok_i,
    input  wire logic [1:0]        enum_valid_i,
    input  wire logic [15:0]       enum_class_i,
    input  wire logic [1:0]        detach_i,
    input  wire logic              kbd_valid_i,
    input  wire logic [7:0]        kbd_data_i,
    input  wire logic              mouse_valid_i,
    input  wire logic [7:0]        mouse_data_i,
    input  wire logic [31:0]       rtc_time_i,
    output logic                   strm_valid_o,
    output logic                   strm_src_o,
    output logic      [7:0]        strm_data_o,
    output logic      [N_CHAN-1:0] strm_chan_o,
    output logic                   stack_clear_o,
    output logic      [1:0]        keyboard_mouse_pair_en_o,
    output logic      [N_CHAN-1:0] chan_led_o,
    output logic      [2:0]        lock_led_o,
    output logic                   fuse_blow_o,
    output logic                   remote_kill_o,
    output logic                   log_wr_o,
    output logic      [1:0]        log_cause_o,
    output logic      [31:0]       log_time_o,
    output psc_pkg::psc_state_type mode_o
);
    import psc_pkg::*;

    localparam int unsigned CW  = $clog2(N_CHAN);
    localparam int unsigned NB  = 2 * N_CHAN;
    localparam int unsigned NP  = NB + 6;
    localparam int unsigned NL  = N_CHAN + 3;
    localparam int unsigned DW  = $clog2(DEBOUNCE_CYC + 1);
    localparam int unsigned DCW = $clog2(DISCARD_CYC + 1);
    localparam int unsigned BW  = $clog2(BLINK_CYC + 1);

    // refuse unserved shapes
    generate
        if (N_CHAN < 2 || N_CHAN > 16 || DISCARD_CYC < 1 || DEBOUNCE_CYC < 1 || BLINK_CYC < 1)
        begin : g_bad
            $error("psc_controller: bad parameters");
        end
    endgenerate

    function automatic logic [N_CHAN-1:0] psc_onehot(input logic [CW-1:0] idx);
        psc_onehot      = '0;
        psc_onehot[idx] = 1'b1;
    endfunction : psc_onehot

    function automatic logic [CW-1:0] psc_first(input logic [N_CHAN-1:0] v);
        psc_first = '0;
        for (int i = N_CHAN - 1; i >= 0; i--)
            if (v[i])
                psc_first = CW'(i);
    endfunction : psc_first

    psc_state_type  state;
    psc_state_type  next_state;
    logic [7:0]     st_cnt;
    logic [4:0]     test_cause;
    logic [CW-1:0]  sel;
    logic [DCW-1:0] disc_cnt;
    logic           remote_dis;
    logic [31:0]    ctrl;
    logic [2:0]     lock_state;
    logic [1:0]     port_ok;
    logic [3:0]     port_code;
    logic [NP-1:0]  pin_meta;
    logic [NP-1:0]  pin_sync;
    logic [NB-1:0]  btn_press;
    logic           kpend;
    logic           mpend;
    logic [7:0]     kdata;
    logic [7:0]     mdata;
    logic           last_mouse;
    logic [BW-1:0]  blink_cnt;
    logic [3:0]     chase_ptr;
    logic [31:0]    key_hist;

    // two-flop pin synchronisers
    wire [NP-1:0] pin_raw = {fuse_blown_i, remote_batt_fail_i, remote_tamper_i,
                             batt_fail_i, tamper_i, iso_echo_i, btn_remote_i, btn_panel_i};
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // synchronised pin levels
    wire [NB-1:0] btn_level  = pin_sync[NB-1:0];
    wire          iso_seen   = pin_sync[NB];
    wire          tamper     = pin_sync[NB+1];
    wire          batt_bad   = pin_sync[NB+2];
    wire          r_tamper   = pin_sync[NB+3];
    wire          r_batt_bad = pin_sync[NB+4];
    wire          fuse_gone  = pin_sync[NB+5];

    // debounce, one pulse per press
    genvar b;
    generate
        for (b = 0; b < NB; b++)
        begin : g_deb
            logic [DW-1:0] cnt;
            logic          stable;
            logic          press;
            assign btn_press[b] = press;
            always_ff @(posedge sys_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    cnt    <= '0;
                    stable <= 1'b0;
                    press  <= 1'b0;
                end
                else
                begin
                    press <= 1'b0;
                    if (btn_level[b] == stable)
                        cnt <= '0;
                    else if (cnt == DW'(DEBOUNCE_CYC - 1))
                    begin
                        cnt    <= '0;
                        stable <= btn_level[b];
                        press  <= btn_level[b];
                    end
                    else
                        cnt <= cnt + 1'b1;
                end
            end
        end
    endgenerate

    // panel or live remote presses
    wire [N_CHAN-1:0] press_any = btn_press[N_CHAN-1:0]
                                | (btn_press[NB-1:N_CHAN] & {N_CHAN{~remote_dis}});
    wire [CW-1:0]     press_idx = psc_first(press_any);
    wire              do_switch = (state == psc_st_run) && (|press_any) && (press_idx != sel);

    // self-test evaluation
    wire settle_end = (state == psc_st_settle) && (st_cnt == 8'(`PSC_SETTLE_CYC - 1));
    wire probe_end  = (state == psc_st_probe) && (st_cnt == 8'(`PSC_PROBE_CYC - 1));
    wire [4:0] cause_now = {iso_seen, ~fw_ok_i, tamper | batt_bad, |btn_level, 1'b0};
    wire [4:0] next_cause = test_cause
                          | ((state == psc_st_probe) ? cause_now : 5'h00)
                          | {4'h0, settle_end & btn_level[0]};
    wire tamper_hit = tamper && (state != psc_st_lock);
    wire batt_hit   = batt_bad && (state == psc_st_probe);
    wire lock_event = tamper_hit || batt_hit || (fuse_gone && state != psc_st_lock);

    // operating state sequence
    always_comb
    begin
        next_state = state;
        case (state)
            psc_st_settle: if (settle_end)
                next_state = next_cause[`PSC_CAUSE_STRAP] ? psc_st_fail : psc_st_probe;
            psc_st_probe:  if (probe_end)
                next_state = (|next_cause) ? psc_st_fail : psc_st_run;
            psc_st_run:    next_state = psc_st_run;
            psc_st_fail:   next_state = psc_st_fail;
            psc_st_lock:   next_state = psc_st_lock;
            default:       next_state = psc_st_settle;
        endcase
        if (lock_event)
            next_state = psc_st_lock;
    end

    // state and test record
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state      <= psc_st_settle;
            st_cnt     <= '0;
            test_cause <= '0;
        end
        else
        begin
            state      <= next_state;
            st_cnt     <= (next_state != state) ? 8'h00 : st_cnt + 8'h01;
            test_cause <= next_cause;
        end
    end

    // selection and discard window
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sel      <= '0;
            disc_cnt <= '0;
        end
        else if (do_switch)
        begin
            sel      <= press_idx;
            disc_cnt <= DCW'(DISCARD_CYC);
        end
        else if (disc_cnt != '0)
            disc_cnt <= disc_cnt - 1'b1;
    end

    // remote control kill latch
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            remote_dis <= 1'b0;
        else if (r_tamper || r_batt_bad)
            remote_dis <= 1'b1;
    end

    // peripheral admission per port, 0 keyboard, 1 mouse
    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : g_port
            psc_port_type pstat;
            logic [7:0]   pclass;
            wire  [7:0]   cls = enum_class_i[8*p +: 8];
            assign port_ok[p]         = (pstat == psc_port_accept);
            assign port_code[2*p +: 2] = pstat;
            always_ff @(posedge sys_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    pstat  <= psc_port_idle;
                    pclass <= 8'h00;
                end
                else if (detach_i[p])
                    pstat <= psc_port_idle;
                else if (enum_valid_i[p])
                begin
                    case (pstat)
                        psc_port_idle:
                        begin
                            pstat  <= (cls == `PSC_CLASS_HID) ? psc_port_accept : psc_port_reject;
                            pclass <= cls;
                        end
                        psc_port_accept: if (cls != pclass)
                            pstat <= psc_port_reject;
                        default: pstat <= pstat;
                    endcase
                end
            end
        end
    endgenerate

    // merge path gates
    wire flow     = (state == psc_st_run) && ctrl[`PSC_CTRL_FLOW_BIT];
    wire kbd_take = flow && kbd_valid_i && port_ok[0] && (disc_cnt == '0) && !do_switch;
    wire ms_take  = flow && mouse_valid_i && port_ok[1] && !do_switch;
    wire send_m   = mpend && (!kpend || !last_mouse);
    wire send_k   = kpend && !send_m;

    // one slot per source
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            kpend      <= 1'b0;
            mpend      <= 1'b0;
            kdata      <= 8'h00;
            mdata      <= 8'h00;
            last_mouse <= 1'b0;
        end
        else if (do_switch || !flow)
        begin
            kpend <= 1'b0;
            mpend <= 1'b0;
        end
        else
        begin
            kpend      <= kbd_take | (kpend & ~send_k);
            mpend      <= ms_take | (mpend & ~send_m);
            kdata      <= kbd_take ? kbd_data_i : kdata;
            mdata      <= ms_take ? mouse_data_i : mdata;
            last_mouse <= send_m ? 1'b1 : (send_k ? 1'b0 : last_mouse);
        end
    end

    // stream out or probe
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            strm_valid_o <= 1'b0;
            strm_src_o   <= 1'b0;
            strm_data_o  <= 8'h00;
            strm_chan_o  <= '0;
        end
        else if (state == psc_st_probe)
        begin
            strm_valid_o <= 1'b1;
            strm_src_o   <= 1'b0;
            strm_data_o  <= `PSC_PROBE_PATTERN;
            strm_chan_o  <= '0;
        end
        else
        begin
            strm_valid_o <= flow && (send_k || send_m);
            strm_src_o   <= send_m;
            strm_data_o  <= send_m ? mdata : kdata;
            strm_chan_o  <= (state == psc_st_run) ? psc_onehot(sel) : '0;
        end
    end

    // lock key tracking
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            lock_state <= 3'b000;
        else if (do_switch)
            lock_state <= 3'b000;
        else if (flow && send_k)
        begin
            lock_state[0] <= lock_state[0] ^ (kdata == `PSC_KEY_CAPS);
            lock_state[1] <= lock_state[1] ^ (kdata == `PSC_KEY_NUM);
            lock_state[2] <= lock_state[2] ^ (kdata == `PSC_KEY_SCROLL);
        end
    end

    // four most recent key codes
    psc_key_memory #(
        .DEPTH (4),
        .WIDTH (8)
    ) u_keys (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .clear_i   (do_switch),
        .wr_i      (flow && send_k),
        .data_i    (kdata),
        .hist_o    (key_hist)
    );

    // led chaser timing
    wire [3:0] chase_len = (state == psc_st_lock) ? 4'(NL) : 4'(N_CHAN);
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            blink_cnt <= '0;
            chase_ptr <= 4'h0;
        end
        else if (blink_cnt == BW'(BLINK_CYC - 1))
        begin
            blink_cnt <= '0;
            chase_ptr <= (chase_ptr >= chase_len - 4'h1) ? 4'h0 : chase_ptr + 4'h1;
        end
        else
            blink_cnt <= blink_cnt + 1'b1;
    end

    // indicators and log
    wire [NL-1:0] chase_vec = NL'(1) << chase_ptr;
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            chan_led_o               <= '0;
            lock_led_o               <= 3'b000;
            fuse_blow_o              <= 1'b0;
            keyboard_mouse_pair_en_o <= 2'b00;
            stack_clear_o            <= 1'b0;
            remote_kill_o            <= 1'b0;
            log_wr_o                 <= 1'b0;
            log_cause_o              <= 2'b00;
            log_time_o               <= 32'h00000000;
            mode_o                   <= psc_st_settle;
        end
        else
        begin
            case (state)
                psc_st_fail: chan_led_o <= chase_vec[N_CHAN-1:0];
                psc_st_lock: chan_led_o <= chase_vec[N_CHAN-1:0];
                default:     chan_led_o <= psc_onehot(sel);
            endcase
            lock_led_o <= (state == psc_st_lock) ? chase_vec[NL-1:N_CHAN]
                        : (state == psc_st_run) ? lock_state : 3'b000;
            fuse_blow_o              <= fuse_blow_o | (state == psc_st_lock);
            keyboard_mouse_pair_en_o <= {2{state == psc_st_run}};
            stack_clear_o            <= do_switch;
            remote_kill_o            <= remote_dis;
            log_wr_o                 <= (tamper_hit || batt_hit);
            if (tamper_hit || batt_hit)
            begin
                log_cause_o <= {batt_hit, tamper_hit};
                log_time_o  <= rtc_time_i;
            end
            mode_o <= state;
        end
    end

    // apb decode
    wire hit_ctrl = (paddr_i == `PSC_ADDR_CTRL);
    wire hit_stat = (paddr_i == `PSC_ADDR_STATUS);
    wire hit_test = (paddr_i == `PSC_ADDR_TEST);
    wire hit_keys = (paddr_i == `PSC_ADDR_KEYS);
    wire addr_ok  = hit_ctrl | hit_stat | hit_test | hit_keys;
    wire apb_acc  = psel_i & penable_i & ~pready_o;
    wire [31:0] status_word = {13'h0000, disc_cnt != '0, fuse_blow_o, remote_dis,
                               port_code, lock_state, state, 4'(sel)};
    wire [31:0] rd_mux = hit_ctrl ? ctrl
                       : hit_stat ? status_word
                       : hit_test ? {27'h0000000, test_cause}
                       : hit_keys ? key_hist : 32'h00000000;

    // one wait state slave
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h00000000;
            pslverr_o <= 1'b0;
            ctrl      <= `PSC_CTRL_RESET;
        end
        else
        begin
            pready_o  <= apb_acc;
            pslverr_o <= apb_acc & ~addr_ok;
            if (apb_acc)
                prdata_o <= pwrite_i ? 32'h00000000 : rd_mux;
            if (psel_i && penable_i && pready_o && pwrite_i && hit_ctrl)
                ctrl <= pwdata_i;
        end
    end

endmodule : psc_controller

`default_nettype wire

// *** logic/psc_defines.svh ***
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// clock and timing figures
`define PSC_CLK_HZ        40000000
`define PSC_DISCARD_MS    100
`define PSC_DEBOUNCE_MS   5
`define PSC_BLINK_MS      250
`define PSC_SETTLE_CYC    4
`define PSC_PROBE_CYC     16

// register byte addresses
`define PSC_ADDR_CTRL     12'h000
`define PSC_ADDR_STATUS   12'h004
`define PSC_ADDR_TEST     12'h008
`define PSC_ADDR_KEYS     12'h00C

// control register
`define PSC_CTRL_RESET    32'h00000001
`define PSC_CTRL_FLOW_BIT 0

// test cause bits
`define PSC_CAUSE_STRAP   0
`define PSC_CAUSE_BUTTON  1
`define PSC_CAUSE_TAMPER  2
`define PSC_CAUSE_FW      3
`define PSC_CAUSE_ISO     4

// usb class, key codes and probe pattern
`define PSC_CLASS_HID     8'h03
`define PSC_KEY_CAPS      8'h39
`define PSC_KEY_NUM       8'h53
`define PSC_KEY_SCROLL    8'h47
`define PSC_PROBE_PATTERN 8'hA5

`endif

// *** logic/psc_key_memory.sv ***
`default_nettype none

module psc_key_memory #(
    parameter int unsigned DEPTH = 4,
    parameter int unsigned WIDTH = 8
) (
    input  wire logic                   sys_clk_i,
    input  wire logic                   nrst_i,
    input  wire logic                   clear_i,
    input  wire logic                   wr_i,
    input  wire logic [WIDTH-1:0]       data_i,
    output logic      [DEPTH*WIDTH-1:0] hist_o
);

    // refuse bad shapes
    generate
        if (DEPTH < 2 || WIDTH < 1)
        begin : g_bad
            $error("psc_key_memory: bad shape");
        end
    endgenerate

    // newest in low slot; clear wipes
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            hist_o <= '0;
        else if (clear_i)
            hist_o <= '0;
        else if (wr_i)
            hist_o <= {hist_o[DEPTH*WIDTH-WIDTH-1:0], data_i};
    end

endmodule : psc_key_memory

`default_nettype wire

// *** logic/psc_pkg.sv ***
`default_nettype none

package psc_pkg;

    // operating state
    typedef enum logic [4:0] {
        psc_st_settle = 5'b00001,
        psc_st_probe  = 5'b00010,
        psc_st_run    = 5'b00100,
        psc_st_fail   = 5'b01000,
        psc_st_lock   = 5'b10000
    } psc_state_type;

    // port admission
    typedef enum logic [1:0] {
        psc_port_idle   = 2'b00,
        psc_port_accept = 2'b01,
        psc_port_reject = 2'b10
    } psc_port_type;

endpackage : psc_pkg

`default_nettype wire

// *** test/psc_controller_chk.sv ***
`default_nettype none

module psc_controller_chk #(
    parameter int unsigned N_CHAN = 4
) (
    input wire logic                   sys_clk_i,
    input wire logic                   nrst_i,
    input wire logic [N_CHAN-1:0]      btn_panel_i,
    input wire logic [N_CHAN-1:0]      btn_remote_i,
    input wire logic                   strm_valid_o,
    input wire logic                   strm_src_o,
    input wire logic [N_CHAN-1:0]      strm_chan_o,
    input wire logic                   stack_clear_o,
    input wire logic [1:0]             keyboard_mouse_pair_en_o,
    input wire logic [N_CHAN-1:0]      chan_led_o,
    input wire logic                   fuse_blow_o,
    input wire logic                   log_wr_o,
    input wire logic [1:0]             log_cause_o,
    input wire psc_pkg::psc_state_type mode_o
);
    import psc_pkg::*;
    // rising edge, idle in reset
    default clocking ck @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    boot_led_a: assert property (
        mode_o == psc_st_settle ##1 mode_o == psc_st_settle |-> chan_led_o == N_CHAN'(1)) else $error("boot led");
    press_only_a: assert property (
        mode_o == psc_st_run && $past(mode_o) == psc_st_run && $changed(strm_chan_o)
        |-> $past(|{btn_panel_i, btn_remote_i}, 4)) else $error("switch without press");
    no_flow_a: assert property (
        mode_o != psc_st_run && $past(mode_o) != psc_st_run |-> strm_chan_o == '0) else $error("flow off run");
    discard_a: assert property (
        stack_clear_o |-> ##3 !(strm_valid_o && !strm_src_o) [*8]) else $error("key in window");
    pair_en_a: assert property (
        keyboard_mouse_pair_en_o[0] == keyboard_mouse_pair_en_o[1]) else $error("pair split");
    lock_hold_a: assert property (
        mode_o == psc_st_lock |=> mode_o == psc_st_lock && fuse_blow_o) else $error("lock left");
    log_entry_a: assert property (
        log_wr_o |-> mode_o != psc_st_lock && log_cause_o != 2'b00 ##1 mode_o == psc_st_lock)
        else $error("bad log");
    fail_hold_a: assert property (
        mode_o == psc_st_fail |=> mode_o == psc_st_fail && !strm_valid_o) else $error("fail flow");
    sel_led_a: assert property (
        mode_o == psc_st_run |-> $onehot(chan_led_o)) else $error("led not one-hot");
endmodule : psc_controller_chk

bind psc_controller psc_controller_chk #(.N_CHAN(N_CHAN)) chk_i (.sys_clk_i, .nrst_i, .btn_panel_i,
    .btn_remote_i, .strm_valid_o, .strm_src_o, .strm_chan_o, .stack_clear_o, .keyboard_mouse_pair_en_o,
    .chan_led_o, .fuse_blow_o, .log_wr_o, .log_cause_o, .mode_o);

`default_nettype wire

// *** test/psc_periph_model.sv ***
`default_nettype none

module psc_periph_model (
    input  wire logic        sys_clk_i,
    output logic [1:0]       enum_valid_o = 2'b00,
    output logic [15:0]      enum_class_o = 16'h0000,
    output logic             kbd_valid_o = 1'b0,
    output logic [7:0]       kbd_data_o = 8'h00,
    output logic             mouse_valid_o = 1'b0,
    output logic [7:0]       mouse_data_o = 8'h00
);
    // one report, then inverted lines
    task automatic enum_port(input int p, input logic [7:0] c);
        @(posedge sys_clk_i);
        {enum_valid_o, enum_class_o} <= {2'(1 << p), c, c};
        @(posedge sys_clk_i);
        {enum_valid_o, enum_class_o} <= {2'b00, ~c, ~c};
    endtask : enum_port

    // one byte per chosen source
    task automatic send(input logic [1:0] s, input logic [7:0] k, input logic [7:0] m);
        @(posedge sys_clk_i);
        {kbd_valid_o, mouse_valid_o, kbd_data_o, mouse_data_o} <= {s[0], s[1], k, m};
        @(posedge sys_clk_i);
        {kbd_valid_o, mouse_valid_o, kbd_data_o, mouse_data_o} <= {2'b00, ~k, ~m};
    endtask : send
endmodule : psc_periph_model

`default_nettype wire

// *** test/tb_peripheral_switch_controller.sv ***
`default_nettype none

module tb_peripheral_switch_controller;
    timeunit 1ns;
    timeprecision 1ps;
    import psc_pkg::*;

    logic sys_clk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, e;
    logic tamper_i = 1'b0, remote_tamper_i = 1'b0, fw_ok_i = 1'b1, batt_fail_i = 1'b0;
    logic remote_batt_fail_i = 1'b0, fuse_blown_i = 1'b0, iso_echo_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, rtc_time_i = 32'h0, r;
    logic [3:0] btn_panel_i = 4'h0, btn_remote_i = 4'h0;
    logic [1:0] detach_i = 2'b00, lc = 2'b00;
    wire logic [1:0] enum_valid_i, keyboard_mouse_pair_en_o, log_cause_o;
    wire logic [15:0] enum_class_i;
    wire logic [7:0] kbd_data_i, mouse_data_i, strm_data_o;
    wire logic [31:0] prdata_o, log_time_o;
    wire logic [3:0] strm_chan_o, chan_led_o;
    wire logic [2:0] lock_led_o;
    wire logic kbd_valid_i, mouse_valid_i, pready_o, pslverr_o, strm_valid_o, strm_src_o;
    wire logic stack_clear_o, fuse_blow_o, remote_kill_o, log_wr_o;
    wire psc_state_type mode_o;
    int failures = 0, checks_done = 0, sel = 0, seed = 32'h30b1;
    logic [7:0] kq[$];
    logic [12:0] eq[2][$];

    psc_controller #(.DISCARD_CYC(40), .DEBOUNCE_CYC(4), .BLINK_CYC(8)) uut (.*);
    psc_periph_model p (.sys_clk_i, .enum_valid_o(enum_valid_i), .enum_class_o(enum_class_i),
        .kbd_valid_o(kbd_valid_i), .kbd_data_o(kbd_data_i), .mouse_valid_o(mouse_valid_i),
        .mouse_data_o(mouse_data_i));

    // clock and time stamp
    always #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) rtc_time_i <= rtc_time_i + 32'h1;

    // stream check, log capture
    always @(posedge sys_clk_i)
    begin
        if (log_wr_o === 1'b1)
            lc <= log_cause_o;
        if (strm_valid_o === 1'b1 && mode_o === psc_st_run)
            chk({strm_src_o, strm_chan_o, strm_data_o},
                eq[strm_src_o].size() ? eq[strm_src_o].pop_front() : 13'h1FFF);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        {r, e} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'b00;
    endtask : apb

    task automatic press(input int i, input int rem, input logic ok);
        @(posedge sys_clk_i);
        {btn_remote_i, btn_panel_i} <= 8'(1 << (i + 4 * rem));
        tick(20);
        {btn_remote_i, btn_panel_i} <= 8'h00;
        tick(10);
        sel = ok ? i : sel;
        kq.delete();
        chk(chan_led_o, 4'(1 << sel));
    endtask : press

    task automatic key(input logic [7:0] k, input logic fwd);
        p.send(2'b01, k, 8'h00);
        if (fwd)
        begin
            eq[0].push_back({1'b0, 4'(1 << sel), k});
            kq.push_back(k);
        end
        tick(4);
    endtask : key

    task automatic boot(input logic hold);
        @(posedge sys_clk_i);
        nrst_i <= 1'b0;
        btn_panel_i <= {3'b000, hold};
        tick(5);
        nrst_i <= 1'b1;
        tick(40);
        btn_panel_i <= 4'h0;
        sel = 0;
    endtask : boot

    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // scenario sequence
    initial
    begin
        boot(1'b0);
        chk(chan_led_o, 4'h1);
        chk(mode_o, psc_st_run);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk({r[30:0], e}, 32'h1);
        p.enum_port(0, 8'h03);
        p.enum_port(1, 8'h09);
        p.send(2'b10, 8'h00, 8'h5A);
        key(8'h39, 1'b1);
        chk(lock_led_o, 3'b001);
        detach_i <= 2'b10;
        tick(2);
        detach_i <= 2'b00;
        p.enum_port(1, 8'h03);
        p.send(2'b11, 8'h21, 8'h42);
        eq[0].push_back({5'b00001, 8'h21});
        eq[1].push_back({5'b10001, 8'h42});
        tick(6);
        press(2, 0, 1'b1);
        key(8'h22, 1'b0);
        tick(40);
        repeat (4) key(8'($random(seed) & 32'h1F), 1'b1);
        apb(1'b0, 12'h00C, 32'h0);
        chk(r, {kq[0], kq[1], kq[2], kq[3]});
        press(1, 1, 1'b1);
        apb(1'b0, 12'h00C, 32'h0);
        chk(r, 32'h0);
        tick(40);
        p.enum_port(0, 8'h08);
        key(8'h23, 1'b0);
        remote_tamper_i <= 1'b1;
        tick(8);
        chk(remote_kill_o, 1'b1);
        press(3, 1, 1'b0);
        tamper_i <= 1'b1;
        tick(8);
        chk(mode_o, psc_st_lock);
        chk({fuse_blow_o, lc}, 3'b101);
        {tamper_i, remote_tamper_i} <= 2'b00;
        boot(1'b1);
        chk(mode_o, psc_st_fail);
        chk(keyboard_mouse_pair_en_o, 2'b00);
        chk(eq[0].size() + eq[1].size(), 0);
        final_report();
    end

    // hang guard
    initial
    begin
        tick(5000);
        failures++;
        final_report();
    end
endmodule : tb_peripheral_switch_controller

`default_nettype wire
